// ### hdl/fpu_decode_pkg.sv
// constants shared by the vector and external instruction decoder
package fpu_decode_pkg;
	// host-issued coprocessor instruction
	localparam logic [4:0] VEC_GROUP_OP = 5'h1F;
	localparam logic [3:0] POLYNOMIAL_EXPAND_OP = 4'h0;
	localparam logic [3:0] MULTIPLY_ACCUMULATE_OP = 4'h1;
	localparam logic [3:0] MINMAX_1D_OP = 4'h2;
	localparam logic [3:0] MINMAX_2D_OP = 4'h3;
	localparam logic [3:0] MATRIX_VEC_MUL_E0_OP = 4'h4;
	localparam logic [3:0] MATRIX_VEC_MUL_E1_OP = 4'h5;
	localparam logic [3:0] MATRIX_VEC_MUL_E2_OP = 4'h6;
	localparam logic [3:0] MATRIX_VEC_MUL_E3_OP = 4'h7;
	localparam logic [3:0] MATRIX_ROW_ADD_OP = 4'h8;
	localparam logic [3:0] VECTOR_ADD_OP = 4'h9;
	localparam logic [3:0] VECTOR_SUBTRACT_OP = 4'hA;
	localparam logic [3:0] DOT_PRODUCT_OP = 4'hB;
	localparam logic [3:0] CROSS_PRODUCT_OP = 4'hC;
	localparam logic [3:0] MAGNITUDE_OP = 4'hD;
	localparam logic [3:0] NORMALIZE_OP = 4'hE;
	localparam logic [3:0] REFLECTION_OP = 4'hF;
	localparam logic [3:0] MATRIX_ROW_LAST = 4'hC;
	// operand precision, {type, size}
	localparam logic [1:0] PREC_INT = 2'h0;
	localparam logic [1:0] PREC_RSVD = 2'h1;
	localparam logic [1:0] PREC_SINGLE = 2'h2;
	localparam logic [1:0] PREC_DOUBLE = 2'h3;
	// external instruction field positions
	localparam int SEQ_HI = 31;
	localparam int SEQ_LO = 28;
	localparam int SRCA_HI = 27;
	localparam int SRCA_LO = 24;
	localparam int SRCB_HI = 23;
	localparam int SRCB_LO = 20;
	localparam int DEST_HI = 19;
	localparam int DEST_LO = 15;
	localparam int SEL_HI = 14;
	localparam int SEL_LO = 11;
	localparam int CLASS_HI = 10;
	localparam int CLASS_LO = 6;
	localparam int ABS_OPND_BIT = 5;
	localparam int ABS_RES_BIT = 4;
	localparam int NEG_RES_BIT = 3;
	localparam int WRAP_BIT = 2;
	localparam int PREC_HI = 1;
	localparam int PREC_LO = 0;
	localparam int COUNT_HI = 7;
	localparam int COUNT_LO = 2;
	// sequencer operation codes
	localparam logic [3:0] SEQ_CONTINUE = 4'h0;
	localparam logic [3:0] SEQ_CONTINUE_WE = 4'h1;
	localparam logic [3:0] SEQ_CONTINUE_ALS = 4'h2;
	localparam logic [3:0] SEQ_TRANSFER = 4'h3;
	localparam logic [3:0] SEQ_BRANCH = 4'h4;
	localparam logic [3:0] SEQ_CALL = 4'h5;
	// arithmetic operation classes
	localparam logic [4:0] OP_ADD = 5'h00;
	localparam logic [4:0] OP_AND = 5'h01;
	localparam logic [4:0] OP_ANDNA = 5'h02;
	localparam logic [4:0] OP_ANDNB = 5'h03;
	localparam logic [4:0] OP_CMP = 5'h04;
	localparam logic [4:0] OP_COMPL = 5'h05;
	localparam logic [4:0] OP_DIV = 5'h06;
	localparam logic [4:0] OP_DTOF = 5'h07;
	localparam logic [4:0] OP_DTOI = 5'h08;
	localparam logic [4:0] DOUBLE_TO_UNSIGNED_OP = 5'h09;
	localparam logic [4:0] OP_FTOD = 5'h0A;
	localparam logic [4:0] OP_FTOI = 5'h0B;
	localparam logic [4:0] SINGLE_TO_UNSIGNED_OP = 5'h0C;
	localparam logic [4:0] OP_ITOD = 5'h0D;
	localparam logic [4:0] OP_ITOF = 5'h0E;
	localparam logic [4:0] FLAGLESS_MOVE_OP = 5'h0F;
	localparam logic [4:0] OP_MULT = 5'h10;
	localparam logic [4:0] CHAINED_MUL_ADD_OP = 5'h11;
	localparam logic [4:0] OP_NEG = 5'h12;
	localparam logic [4:0] OP_OR = 5'h13;
	localparam logic [4:0] OP_NOR = 5'h14;
	localparam logic [4:0] OP_PASS = 5'h15;
	// transfer and flow sub-codes
	localparam logic [4:0] REGISTER_LOAD_OP = 5'h00;
	localparam logic [4:0] LOCAL_TO_MEMSIDE_MOVE_OP = 5'h01;
	localparam logic [4:0] MEMSIDE_TO_LOCAL_MOVE_OP = 5'h02;
	localparam logic [4:0] REG_TO_REG_MULTI_MOVE_OP = 5'h03;
	localparam logic [4:0] COND_JUMP_OP = 5'h00;
	localparam logic [4:0] COND_SUBROUTINE_JUMP_OP = 5'h01;
	localparam logic [4:0] LOOP_COUNT_LOAD_OP = 5'h02;
	localparam logic [4:0] COPY_ADDRESS_LOAD_OP = 5'h03;
	localparam logic [4:0] MASK_SET_OP = 5'h04;
	// operand sources
	localparam logic [1:0] SRC_REGFILE = 2'h0;
	localparam logic [1:0] SRC_FEEDBACK = 2'h1;
	localparam logic [1:0] SRC_LOCAL_BUS = 2'h2;
	// pipeline stage settings and cycle counts
	localparam logic [1:0] PIPE_NONE = 2'h0;
	localparam logic [1:0] PIPE_ALL = 2'h3;
	localparam logic [1:0] PIPE_HI_ONLY = 2'h2;
	localparam logic [7:0] LAT_ONE = 8'h01;
	localparam logic [7:0] LAT_TWO = 8'h02;
	localparam logic [7:0] LAT_THREE = 8'h03;
	localparam logic [7:0] DIV_LAT_SP_A = 8'h08;
	localparam logic [7:0] DIV_LAT_SP_B = 8'h09;
	localparam logic [7:0] DIV_LAT_DP_A = 8'h0D;
	localparam logic [7:0] DIV_LAT_DP_B = 8'h0F;
	localparam logic [7:0] DIV_LAT_INT_A = 8'h10;
	localparam logic [7:0] DIV_LAT_INT_B = 8'h11;
	localparam logic [7:0] DIV_IVL_SP_B = 8'h07;
	localparam logic [7:0] DIV_IVL_DP_B = 8'h0C;
	localparam logic [7:0] DIV_IVL_INT_B = 8'h0F;
	// software registers
	localparam logic [3:0] REG_CONFIG = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_COUNT = 4'h8;
	localparam int CFG_PIPE_HI = 1;
	localparam int CFG_PIPE_LO = 0;
	localparam int CFG_HOSTIND_BIT = 2;
	localparam logic [1:0] CFG_PIPE_RESET = 2'h3;
	localparam logic CFG_HOSTIND_RESET = 1'b0;
	typedef enum logic [4:0] {
		FMT_NONE = 5'b00001,
		FMT_ARITH = 5'b00010,
		FMT_TRANSFER = 5'b00100,
		FMT_BRANCH = 5'b01000,
		FMT_CALL = 5'b10000
	} fmt_t;
endpackage

// ### hdl/fpu_vector_and_external_instr_decode.sv
// decoder for vector sub-opcodes and external 32-bit instructions
//
// Contract
// - vector group decodes poly, mac, minmax subcodes
// - 0100-0111 multiply matrix row by element
// - 1000 row add, 1001 add, 1010 subtract
// - 1011 dot, 1100 cross, 1101 magnitude
// - 1110 normalize, 1111 reflection vector
// - external word is 32 bits, four formats
// - arithmetic fields from bit 31 down to 0
// - operands from registers, feedback or bus
// - two of the three continue codes drive bus strobes
// - source and destination address own registers
// - source select picks registers, feedback or bus
// - abs, negate and wrapped input options
// - chained op runs multiplier and alu together
// - latency follows two-bit pipeline setting
// - single-stage ops take 1, 2, 3 cycles
// - divide uses its own tabulated counts
// - flow ops, loop count and copy address loads take one cycle
// - transfers take n+1 or 2n+1 cycles
// - conversions among double, single, integer, unsigned
// - flagless move leaves status flags alone
// - coprocessor op code is five bits
// - op code 11111 turns source b into subcode
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fpu_vector_and_external_instr_decode (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_strobe_in,
	input wire logic rd_strobe_in,
	output logic [31:0] rdata_out,
	input wire logic cop_valid_in,
	input wire logic [4:0] cop_opcode_in,
	input wire logic [3:0] cop_source_b_in,
	input wire logic [1:0] cop_precision_in,
	output logic vec_valid_out,
	output logic [3:0] vec_op_out,
	output logic [3:0] vec_matrix_base_out,
	output logic [1:0] vec_element_out,
	output logic [1:0] vec_precision_out,
	output logic vec_error_out,
	input wire logic ext_valid_in,
	input wire logic [31:0] ext_word_in,
	output logic ext_ready_out,
	output logic ext_valid_out,
	output fpu_decode_pkg::fmt_t ext_format_out,
	output logic [4:0] ext_class_out,
	output logic [3:0] source_a_field_out,
	output logic [3:0] source_b_field_out,
	output logic [4:0] dest_field_out,
	output logic [1:0] source_a_sel_out,
	output logic [1:0] source_b_sel_out,
	output logic abs_operand_out,
	output logic abs_result_out,
	output logic negate_result_out,
	output logic wrapped_input_out,
	output logic [1:0] ext_precision_out,
	output logic chained_out,
	output logic flags_update_out,
	output logic [7:0] latency_out,
	output logic ext_error_out,
	output logic write_strobe_out,
	output logic address_latch_strobe_out
);
	import fpu_decode_pkg::*;

	typedef struct packed {
		logic [31:0] rdata;
		logic [1:0] pipe;
		logic host_ind;
		logic [15:0] count;
		logic [7:0] ivl;
		logic ready;
		logic vvalid;
		logic [3:0] vop;
		logic [3:0] vbase;
		logic [1:0] velem;
		logic [1:0] vprec;
		logic verr;
		logic evalid;
		fmt_t fmt;
		logic [4:0] cls;
		logic [3:0] sa;
		logic [3:0] sb;
		logic [4:0] dst;
		logic [1:0] sela;
		logic [1:0] selb;
		logic absop;
		logic absres;
		logic negres;
		logic wrap;
		logic [1:0] prec;
		logic chained;
		logic flags;
		logic [7:0] lat;
		logic eerr;
		logic we;
		logic als;
	} state_t;

	state_t q;
	state_t d;

	// cycles of a one-stage-per-pipeline op
	function automatic logic [7:0] stage_lat(input logic [1:0] pipe);
		if (pipe == PIPE_ALL) begin
			stage_lat = LAT_ONE;
		end else if (pipe == PIPE_NONE) begin
			stage_lat = LAT_THREE;
		end else begin
			stage_lat = LAT_TWO;
		end
	endfunction

	always_comb begin
		logic [3:0] seq;
		logic [4:0] cls;
		logic [1:0] prec;
		logic [5:0] n;
		logic [7:0] ivl;
		logic [7:0] lat;
		logic err;
		seq = ext_word_in[SEQ_HI:SEQ_LO];
		cls = ext_word_in[CLASS_HI:CLASS_LO];
		prec = ext_word_in[PREC_HI:PREC_LO];
		n = ext_word_in[COUNT_HI:COUNT_LO];
		ivl = LAT_ONE;
		lat = LAT_ONE;
		err = 1'b0;
		d = q;
		d.vvalid = 1'b0;
		d.evalid = 1'b0;
		d.we = 1'b0;
		d.als = 1'b0;
		d.rdata = 32'h0000_0000;
		// issue interval counts down while a slow op runs
		if (q.ivl != 8'h00) begin
			d.ivl = q.ivl - 8'h01;
		end

		// register port
		if (wr_strobe_in && addr_in == REG_CONFIG) begin
			d.pipe = wdata_in[CFG_PIPE_HI:CFG_PIPE_LO];
			d.host_ind = wdata_in[CFG_HOSTIND_BIT];
		end
		if (rd_strobe_in) begin
			case (addr_in)
				REG_CONFIG: d.rdata = {29'h0000_0000, q.host_ind, q.pipe};
				REG_STATUS: d.rdata = {23'h00_0000, q.verr, q.eerr, q.ready, 1'b0, q.fmt};
				REG_COUNT: d.rdata = {16'h0000, q.count};
				default: d.rdata = 32'h0000_0000;
			endcase
		end

		// host vector group: five-bit op code, source b reused as subcode
		if (cop_valid_in && cop_opcode_in == VEC_GROUP_OP) begin
			d.vvalid = 1'b1;
			d.vop = cop_source_b_in;
			d.vprec = cop_precision_in;
			d.verr = (cop_precision_in == PREC_RSVD);
			d.vbase = MATRIX_ROW_LAST;
			d.velem = 2'h0;
			case (cop_source_b_in)
				MATRIX_VEC_MUL_E0_OP, MATRIX_VEC_MUL_E1_OP,
				MATRIX_VEC_MUL_E2_OP, MATRIX_VEC_MUL_E3_OP: begin
					d.velem = cop_source_b_in[1:0];
					d.vbase = {cop_source_b_in[1:0], 2'h0};
				end
				MATRIX_ROW_ADD_OP: begin
					d.vbase = MATRIX_ROW_LAST;
				end
				default: begin
					d.vbase = MATRIX_ROW_LAST;
				end
			endcase
		end

		// external instruction, taken only when the issue slot is free
		if (ext_valid_in && q.ivl == 8'h00) begin
			d.evalid = 1'b1;
			d.count = q.count + 16'h0001;
			d.cls = cls;
			d.sa = ext_word_in[SRCA_HI:SRCA_LO];
			d.sb = ext_word_in[SRCB_HI:SRCB_LO];
			d.dst = ext_word_in[DEST_HI:DEST_LO];
			d.sela = ext_word_in[SEL_LO+1:SEL_LO];
			d.selb = ext_word_in[SEL_HI:SEL_LO+2];
			d.prec = prec;
			d.absop = 1'b0;
			d.absres = 1'b0;
			d.negres = 1'b0;
			d.wrap = 1'b0;
			d.chained = 1'b0;
			d.flags = 1'b0;
			case (seq)
				SEQ_CONTINUE, SEQ_CONTINUE_WE, SEQ_CONTINUE_ALS: begin
					d.fmt = FMT_ARITH;
					d.absop = ext_word_in[ABS_OPND_BIT];
					d.absres = ext_word_in[ABS_RES_BIT];
					d.negres = ext_word_in[NEG_RES_BIT];
					d.wrap = ext_word_in[WRAP_BIT];
					d.flags = (cls != FLAGLESS_MOVE_OP);
					d.chained = (cls == CHAINED_MUL_ADD_OP);
					if (q.host_ind) begin
						d.we = (seq == SEQ_CONTINUE_WE);
						d.als = (seq == SEQ_CONTINUE_ALS);
					end
					// the bus carries one 32-bit word per operand
					if ((d.sela == SRC_LOCAL_BUS || d.selb == SRC_LOCAL_BUS)
						&& prec == PREC_DOUBLE) begin
						err = 1'b1;
					end
					if (d.sela > SRC_LOCAL_BUS || d.selb > SRC_LOCAL_BUS
						|| prec == PREC_RSVD || cls > OP_PASS) begin
						err = 1'b1;
					end
					lat = stage_lat(q.pipe);
					ivl = LAT_ONE;
					case (cls)
						// divide rows differ per pipeline column
						OP_DIV: begin
							if (prec == PREC_SINGLE) begin
								lat = q.pipe[0] ? DIV_LAT_SP_A : DIV_LAT_SP_B;
								ivl = (q.pipe == PIPE_ALL) ? DIV_LAT_SP_A : DIV_IVL_SP_B;
							end else if (prec == PREC_DOUBLE) begin
								lat = q.pipe[0] ? DIV_LAT_DP_A : DIV_LAT_DP_B;
								ivl = (q.pipe == PIPE_ALL) ? DIV_LAT_DP_A : DIV_IVL_DP_B;
							end else begin
								lat = q.pipe[0] ? DIV_LAT_INT_A : DIV_LAT_INT_B;
								ivl = (q.pipe == PIPE_ALL) ? DIV_LAT_INT_A : DIV_IVL_INT_B;
							end
							if (q.pipe == PIPE_HI_ONLY) begin
								if (prec == PREC_SINGLE) begin
									lat = DIV_LAT_SP_A;
								end else if (prec == PREC_DOUBLE) begin
									lat = DIV_LAT_DP_A;
								end else begin
									lat = DIV_LAT_INT_A;
								end
							end
						end
						OP_MULT, CHAINED_MUL_ADD_OP: begin
							if (prec == PREC_DOUBLE) begin
								lat = stage_lat(q.pipe) + 8'h01;
								ivl = LAT_TWO;
							end
						end
						OP_DTOF, OP_DTOI, DOUBLE_TO_UNSIGNED_OP, OP_FTOD, OP_FTOI,
						SINGLE_TO_UNSIGNED_OP, OP_ITOD, OP_ITOF: begin
							lat = stage_lat(q.pipe);
						end
						default: begin
							lat = stage_lat(q.pipe);
						end
					endcase
				end
				// transfers hold the issue slot for every word
				SEQ_TRANSFER: begin
					d.fmt = FMT_TRANSFER;
					if (cls > REG_TO_REG_MULTI_MOVE_OP || prec == PREC_RSVD) begin
						err = 1'b1;
					end
					if (prec == PREC_DOUBLE) begin
						lat = {1'b0, n, 1'b1};
					end else begin
						lat = {2'h0, n} + 8'h01;
					end
					ivl = lat;
				end
				// flow ops ignore the pipeline setting
				SEQ_BRANCH: begin
					d.fmt = FMT_BRANCH;
					err = (cls > MASK_SET_OP);
					lat = LAT_ONE;
					ivl = LAT_ONE;
				end
				SEQ_CALL: begin
					d.fmt = FMT_CALL;
					lat = LAT_ONE;
					ivl = LAT_ONE;
				end
				default: begin
					d.fmt = FMT_NONE;
					err = 1'b1;
				end
			endcase
			// latency and next free issue slot
			d.eerr = err;
			d.lat = lat;
			d.ivl = ivl - 8'h01;
		end

		// ready mirrors an empty issue interval
		d.ready = (d.ivl == 8'h00);
	end

	// state register
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			q <= '{
				rdata: 32'h0000_0000,
				pipe: CFG_PIPE_RESET,
				host_ind: CFG_HOSTIND_RESET,
				count: 16'h0000,
				ivl: 8'h00,
				ready: 1'b1,
				vvalid: 1'b0,
				vop: 4'h0,
				vbase: 4'h0,
				velem: 2'h0,
				vprec: 2'h0,
				verr: 1'b0,
				evalid: 1'b0,
				fmt: FMT_NONE,
				cls: 5'h00,
				sa: 4'h0,
				sb: 4'h0,
				dst: 5'h00,
				sela: 2'h0,
				selb: 2'h0,
				absop: 1'b0,
				absres: 1'b0,
				negres: 1'b0,
				wrap: 1'b0,
				prec: 2'h0,
				chained: 1'b0,
				flags: 1'b0,
				lat: 8'h00,
				eerr: 1'b0,
				we: 1'b0,
				als: 1'b0
			};
		end else begin
			q <= d;
		end
	end

	// outputs straight from the state flip-flops
	assign rdata_out = q.rdata;
	assign vec_valid_out = q.vvalid;
	assign vec_op_out = q.vop;
	assign vec_matrix_base_out = q.vbase;
	assign vec_element_out = q.velem;
	assign vec_precision_out = q.vprec;
	assign vec_error_out = q.verr;
	assign ext_ready_out = q.ready;
	assign ext_valid_out = q.evalid;
	assign ext_format_out = q.fmt;
	assign ext_class_out = q.cls;
	assign source_a_field_out = q.sa;
	assign source_b_field_out = q.sb;
	assign dest_field_out = q.dst;
	assign source_a_sel_out = q.sela;
	assign source_b_sel_out = q.selb;
	assign abs_operand_out = q.absop;
	assign abs_result_out = q.absres;
	assign negate_result_out = q.negres;
	assign wrapped_input_out = q.wrap;
	assign ext_precision_out = q.prec;
	assign chained_out = q.chained;
	assign flags_update_out = q.flags;
	assign latency_out = q.lat;
	assign ext_error_out = q.eerr;
	assign write_strobe_out = q.we;
	assign address_latch_strobe_out = q.als;
endmodule // fpu_vector_and_external_instr_decode
`default_nettype wire

// ### verif/fpu_decode_sva.sv
// assertions on the decoder ports
`timescale 1ns/1ps
`default_nettype none
module fpu_decode_sva
	import fpu_decode_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic cop_valid_in,
	input wire logic [4:0] cop_opcode_in,
	input wire logic [3:0] cop_source_b_in,
	input wire logic vec_valid_out,
	input wire logic [3:0] vec_op_out,
	input wire logic [3:0] vec_matrix_base_out,
	input wire logic [1:0] vec_element_out,
	input wire logic ext_valid_in,
	input wire logic [31:0] ext_word_in,
	input wire logic ext_ready_out,
	input wire logic ext_valid_out,
	input wire fpu_decode_pkg::fmt_t ext_format_out,
	input wire logic [4:0] ext_class_out,
	input wire logic [3:0] source_a_field_out,
	input wire logic [3:0] source_b_field_out,
	input wire logic [4:0] dest_field_out,
	input wire logic chained_out,
	input wire logic flags_update_out,
	input wire logic [7:0] latency_out,
	input wire logic write_strobe_out,
	input wire logic address_latch_strobe_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	a_vec_decode: assert property (cop_valid_in && cop_opcode_in == VEC_GROUP_OP |=>
		vec_valid_out && vec_op_out == $past(cop_source_b_in)) else $error("vector decode wrong");
	a_vec_ignore: assert property (!(cop_valid_in && cop_opcode_in == VEC_GROUP_OP) |=>
		!vec_valid_out) else $error("vector pulse without cause");
	a_row_select: assert property (vec_valid_out && vec_op_out[3:2] == 2'h1 |->
		vec_matrix_base_out == {vec_op_out[1:0], 2'h0} && vec_element_out == vec_op_out[1:0])
		else $error("matrix row or element wrong");
	a_ext_take: assert property (ext_valid_in && ext_ready_out |=> ext_valid_out &&
		source_a_field_out == $past(ext_word_in[27:24]) &&
		source_b_field_out == $past(ext_word_in[23:20]) &&
		dest_field_out == $past(ext_word_in[19:15])) else $error("external fields wrong");
	a_ext_refuse: assert property (!(ext_valid_in && ext_ready_out) |=> !ext_valid_out)
		else $error("external pulse without taken word");
	a_flow_one: assert property (ext_valid_out && ext_format_out inside {FMT_BRANCH, FMT_CALL}
		|-> latency_out == LAT_ONE) else $error("flow latency not one");
	a_flag_move: assert property (ext_valid_out && ext_format_out == FMT_ARITH |->
		flags_update_out == (ext_class_out != FLAGLESS_MOVE_OP)) else $error("flag update wrong");
	a_chain_op: assert property (ext_valid_out && ext_format_out == FMT_ARITH |->
		chained_out == (ext_class_out == CHAINED_MUL_ADD_OP)) else $error("chained flag wrong");
	a_strobe_with: assert property (write_strobe_out || address_latch_strobe_out |->
		ext_valid_out) else $error("strobe outside decode pulse");
	a_div_busy: assert property (ext_valid_out && ext_format_out == FMT_ARITH &&
		ext_class_out == OP_DIV && latency_out == DIV_LAT_SP_B |-> !ext_ready_out [*6] ##1
		ext_ready_out) else $error("divide issue gap wrong");
endmodule // fpu_decode_sva
bind fpu_vector_and_external_instr_decode fpu_decode_sva fpu_decode_sva_i (.*);
`default_nettype wire

// ### verif/fpu_vector_and_external_instr_decode_tb_top.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module fpu_vector_and_external_instr_decode_tb_top;
	import fpu_decode_pkg::*;
	logic mclk_in = 0, rst_in = 1, wr_strobe_in = 0, rd_strobe_in = 0, cop_valid_in = 0, req = 0;
	logic [3:0] addr_in = 4'h0, cop_source_b_in = 4'h0;
	logic [4:0] cop_opcode_in = 5'h00;
	logic [1:0] cop_precision_in = 2'h0;
	logic [31:0] wdata_in = 32'h0, word = 32'h0, rdata_out, ext_word_in;
	logic vec_valid_out, vec_error_out, ext_valid_in, ext_ready_out, ext_valid_out, ext_error_out;
	logic abs_operand_out, abs_result_out, negate_result_out, wrapped_input_out, chained_out;
	logic flags_update_out, write_strobe_out, address_latch_strobe_out, ws, als;
	logic [3:0] vec_op_out, vec_matrix_base_out, source_a_field_out, source_b_field_out;
	logic [1:0] vec_element_out, vec_precision_out, source_a_sel_out, source_b_sel_out;
	logic [1:0] ext_precision_out;
	logic [4:0] ext_class_out, dest_field_out;
	logic [7:0] latency_out;
	fmt_t ext_format_out;
	int bad_count = 0, n_checks = 0, lows;
	always #12.5 mclk_in = ~mclk_in;
	fpu_vector_and_external_instr_decode fpu_vector_and_external_instr_decode_i (.*);
	instr_feed instr_feed_i (.mclk_in, .rst_in, .req_in(req), .word_in(word),
		.ready_in(ext_ready_out), .valid_out(ext_valid_in), .word_out(ext_word_in));
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(logic [3:0] a, logic [31:0] d);
		@(posedge mclk_in);
		wr_strobe_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge mclk_in);
		wr_strobe_in <= 1'b0;
	endtask
	task automatic rd(logic [3:0] a, logic [31:0] e);
		@(posedge mclk_in);
		rd_strobe_in <= 1'b1;
		addr_in <= a;
		@(posedge mclk_in);
		rd_strobe_in <= 1'b0;
		@(negedge mclk_in);
		chk("rdata", e, rdata_out);
	endtask
	task automatic vec(logic [4:0] o, logic [3:0] b, logic [1:0] p);
		@(posedge mclk_in);
		cop_valid_in <= 1'b1;
		cop_opcode_in <= o;
		cop_source_b_in <= b;
		cop_precision_in <= p;
		@(posedge mclk_in);
		cop_valid_in <= 1'b0;
		@(negedge mclk_in);
	endtask
	// issues one word, captures the strobes, counts cycles with ready low
	task automatic ext(logic [31:0] w);
		int i;
		@(posedge mclk_in);
		req <= 1'b1;
		word <= w;
		@(posedge mclk_in);
		req <= 1'b0;
		for (i = 0; i < 40; i++) begin
			@(negedge mclk_in);
			if (ext_valid_out === 1'b1) break;
		end
		ws = write_strobe_out;
		als = address_latch_strobe_out;
		for (lows = 0; lows < 40 && ext_ready_out !== 1'b1; lows++) @(negedge mclk_in);
		if (i == 40 || lows == 40) begin
			bad_count++;
			close_out();
		end
	endtask
	function automatic logic [31:0] mk(logic [3:0] sq, logic [4:0] cl, logic [1:0] pr,
		logic [3:0] sel, logic [3:0] o);
		return {sq, 4'h5, 4'hA, 5'h13, sel, cl, o, pr};
	endfunction
	task automatic t_regs();
		rd(REG_CONFIG, 32'h3);
		rd(REG_STATUS, 32'h41);
		wr(REG_STATUS, 32'hFF);
		rd(REG_STATUS, 32'h41);
		rd(4'hC, 32'h0);
		$display("register test done");
	endtask
	task automatic t_vec();
		logic [3:0] b;
		for (int i = 0; i < 16; i++) begin
			b = 4'(i);
			vec(VEC_GROUP_OP, b, PREC_SINGLE);
			chk("vec_valid", 1'b1, vec_valid_out);
			chk("vec_op", b, vec_op_out);
			chk("base", b[3:2] == 2'h1 ? {b[1:0], 2'h0} : 4'hC, vec_matrix_base_out);
			chk("element", b[3:2] == 2'h1 ? b[1:0] : 2'h0, vec_element_out);
		end
		chk("vec_prec", PREC_SINGLE, vec_precision_out);
		vec(VEC_GROUP_OP, 4'h9, PREC_RSVD);
		chk("vec_error", 1'b1, vec_error_out);
		vec(5'h1E, 4'h3, PREC_DOUBLE);
		chk("vec_quiet", 1'b0, vec_valid_out);
		$display("vector test done");
	endtask
	task automatic t_lat();
		for (int p = 3; p >= 0; p--) begin
			wr(REG_CONFIG, 32'(p));
			ext(mk(SEQ_CONTINUE, OP_ADD, PREC_SINGLE, 4'h0, 4'h0));
			chk("lat", p == 3 ? LAT_ONE : (p == 0 ? LAT_THREE : LAT_TWO), latency_out);
			chk("gap", 0, lows);
			chk("flags", 1'b1, flags_update_out);
		end
		ext(mk(SEQ_CONTINUE, FLAGLESS_MOVE_OP, PREC_SINGLE, 4'h0, 4'h0));
		chk("flagless_move_op_flags", 1'b0, flags_update_out);
		chk("flagless_move_op_lat", LAT_THREE, latency_out);
		ext(mk(SEQ_CONTINUE, SINGLE_TO_UNSIGNED_OP, PREC_SINGLE, 4'h0, 4'h0));
		chk("conv_fmt", FMT_ARITH, ext_format_out);
		chk("conv_err", 1'b0, ext_error_out);
		chk("conv_lat", LAT_THREE, latency_out);
		$display("latency test done");
	endtask
	task automatic t_div();
		logic [1:0] pr [3] = '{PREC_SINGLE, PREC_DOUBLE, PREC_INT};
		logic [7:0] lt [3] = '{DIV_LAT_SP_A, DIV_LAT_DP_A, DIV_LAT_INT_A};
		wr(REG_CONFIG, 32'h3);
		for (int i = 0; i < 3; i++) begin
			ext(mk(SEQ_CONTINUE, OP_DIV, pr[i], 4'h0, 4'h0));
			chk("div_lat", lt[i], latency_out);
			chk("div_gap", lt[i] - 8'h1, lows);
		end
		wr(REG_CONFIG, 32'h0);
		ext(mk(SEQ_CONTINUE, OP_DIV, PREC_SINGLE, 4'h0, 4'h0));
		chk("div_lat", DIV_LAT_SP_B, latency_out);
		chk("div_gap", DIV_IVL_SP_B - 8'h1, lows);
		$display("divide test done");
	endtask
	task automatic t_flow();
		for (int c = 0; c < 5; c++) begin
			ext(mk(SEQ_BRANCH, 5'(c), PREC_SINGLE, 4'h0, 4'h0));
			chk("br_fmt", FMT_BRANCH, ext_format_out);
			chk("br_lat", LAT_ONE, latency_out);
		end
		ext(mk(SEQ_CALL, 5'h0, PREC_SINGLE, 4'h0, 4'h0));
		chk("call_fmt", FMT_CALL, ext_format_out);
		ext(mk(SEQ_TRANSFER, REGISTER_LOAD_OP, PREC_SINGLE, 4'h0, 4'h5));
		chk("ld_lat", 8'd6, latency_out);
		chk("ld_gap", 5, lows);
		ext(mk(SEQ_TRANSFER, LOCAL_TO_MEMSIDE_MOVE_OP, PREC_DOUBLE, 4'h0, 4'h1));
		chk("mv_lat", 8'd35, latency_out);
		chk("mv_fmt", FMT_TRANSFER, ext_format_out);
		$display("flow and transfer test done");
	endtask
	task automatic t_fields();
		wr(REG_CONFIG, 32'h7);
		ext(mk(SEQ_CONTINUE_WE, CHAINED_MUL_ADD_OP, PREC_SINGLE, 4'h6, 4'hA));
		chk("src", 13'hB53, {source_a_field_out, source_b_field_out, dest_field_out});
		chk("sel", 4'h9, {source_a_sel_out, source_b_sel_out});
		chk("opts", 4'hA, {abs_operand_out, abs_result_out, negate_result_out,
			wrapped_input_out});
		chk("chain", 1'b1, chained_out);
		chk("we", 1'b1, ws);
		chk("bus_ok", 1'b0, ext_error_out);
		ext(mk(SEQ_CONTINUE_ALS, OP_MULT, PREC_DOUBLE, 4'h2, 4'h5));
		chk("als", 1'b1, als);
		chk("opts2", 2'h3, {abs_result_out, wrapped_input_out});
		chk("bus_dp", 1'b1, ext_error_out);
		chk("ext_prec", PREC_DOUBLE, ext_precision_out);
		chk("mul_gap", 1, lows);
		wr(REG_CONFIG, 32'h3);
		ext(mk(SEQ_CONTINUE_WE, OP_ADD, PREC_SINGLE, 4'h0, 4'h0));
		chk("we_off", 1'b0, ws);
		rd(REG_COUNT, 32'h15);
		$display("field test done");
	endtask
	initial begin
		repeat (20) @(posedge mclk_in);
		rst_in <= 1'b0;
		t_regs();
		t_vec();
		t_lat();
		t_div();
		t_flow();
		t_fields();
		close_out();
	end
endmodule // fpu_vector_and_external_instr_decode_tb_top
`default_nettype wire

// ### verif/instr_feed.sv
// instruction memory side: offers each word until the decoder takes it
`timescale 1ns/1ps
`default_nettype none
module instr_feed (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic [31:0] word_in,
	input wire logic ready_in,
	output logic valid_out,
	output logic [31:0] word_out
);
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			valid_out <= 1'b0;
			word_out <= 32'h0;
		end else if (valid_out && ready_in) begin
			valid_out <= 1'b0;
			word_out <= ~word_out; // released word does not stay readable
		end else if (req_in) begin
			valid_out <= 1'b1; // one whole word held until taken
			word_out <= word_in;
		end
	end
endmodule // instr_feed
`default_nettype wire
